// ==== src/pre_corrector_excite.sv ====
/*
 pre-corrector sine excitation: start checks, positioner state, per-tick sine
 terms added to the corrector inputs, and the post-corrector output adder.
 assumes servo_tick is a one-cycle pulse per servo cycle, spaced over 3 cycles.
*/
//
// Contract
// - all four outputs are recomputed once per servo tick, at up to 10 kHz.
// - outputs are A*cos-A, -Aw*sin, -Aw^2*cos and Aw^3*sin with w = 2*pi*F.
// - the four terms are updated together in one cycle with one valid strobe.
// - a start is accepted only for the three feed-forward loop types.
// - a start is accepted only while the positioner is ready.
// - the positioner shows the excitation state while running, then ready or not ready as group_ready says.
// - frequency must lie from 0.1 Hz up to 0.5 over the servo period.
// - amplitude and duration must both be above zero.
// - setpoint must not exceed the upper bound, setpoint minus 2A not below lower.
// - peak velocity and acceleration must be non-negative and within their caps.
// - the excitation is added to the corrector inputs, ahead of the PID.
// - the post-corrector excitation is added to the corrector output.
// - the last accepted frequency, amplitude and duration can be read back.
// - capture of commanded and feedback position is enabled while running.
module pre_corrector_excite
   import excite_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic servo_tick,
   // group status
   input wire logic group_ready,
   input wire logic [2:0] loop_type,
   // start command
   input wire logic pre_corrector_excite_start,
   input wire logic [excite_pkg::FW-1:0] freq_mhz,
   input wire logic signed [excite_pkg::DW-1:0] amplitude,
   input wire logic [excite_pkg::TW-1:0] duration_ticks,
   output logic start_ack_reg,
   output logic start_err_reg,
   output logic [3:0] err_code_reg,
   // limits
   input wire logic signed [excite_pkg::DW-1:0] setpoint_pos,
   input wire logic signed [excite_pkg::DW-1:0] upper_travel_bound,
   input wire logic signed [excite_pkg::DW-1:0] lower_travel_bound,
   input wire logic signed [excite_pkg::DW-1:0] velocity_cap,
   input wire logic signed [excite_pkg::DW-1:0] accel_cap,
   // state and readback
   output logic [1:0] pos_state_reg,
   output logic capture_enable_reg,
   output logic [excite_pkg::FW-1:0] param_freq_reg,
   output logic signed [excite_pkg::DW-1:0] param_amp_reg,
   output logic [excite_pkg::TW-1:0] param_dur_reg,
   // excitation terms
   output logic sine_valid_reg,
   output logic signed [excite_pkg::DW-1:0] sine_pos_out_reg,
   output logic signed [excite_pkg::DW-1:0] sine_vel_out_reg,
   output logic signed [excite_pkg::DW-1:0] sine_acc_out_reg,
   output logic signed [excite_pkg::DW-1:0] sine_jerk_out_reg,
   // corrector inputs
   input wire logic signed [excite_pkg::DW-1:0] traj_pos,
   input wire logic signed [excite_pkg::DW-1:0] traj_vel,
   input wire logic signed [excite_pkg::DW-1:0] traj_acc,
   input wire logic signed [excite_pkg::DW-1:0] traj_jerk,
   output logic signed [excite_pkg::DW-1:0] corr_pos_in_reg,
   output logic signed [excite_pkg::DW-1:0] corr_vel_in_reg,
   output logic signed [excite_pkg::DW-1:0] corr_acc_in_reg,
   output logic signed [excite_pkg::DW-1:0] corr_jerk_in_reg,
   // post-corrector path
   input wire logic post_corrector_excite_start,
   input wire logic signed [excite_pkg::DW-1:0] pid_out,
   input wire logic signed [excite_pkg::DW-1:0] post_excite_sig,
   output logic signed [excite_pkg::DW-1:0] drive_out_reg
);
   import excite_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   excite_state_t state_reg;
   logic [FW-1:0] freq_lat;
   logic signed [DW-1:0] amp_lat;
   logic [TW-1:0] dur_lat;
   logic signed [31:0] omega_reg;
   logic signed [DW-1:0] peak_v_reg;
   logic signed [DW-1:0] peak_a_reg;
   logic signed [DW-1:0] peak_j_reg;
   logic [PHW-1:0] phase_reg;
   logic [PHW-1:0] step_reg;
   logic [TW-1:0] elapsed_reg;
   logic look_reg;
   logic end_run;
   logic [3:0] check_err;
   logic signed [SINW-1:0] sin_q;
   logic signed [SINW-1:0] cos_q;

   function automatic logic signed [DW-1:0] mulq(input logic signed [DW-1:0] a,
                                                input logic signed [31:0] b,
                                                input int sh);
      logic signed [DW+31:0] p;
      p = a * b;
      return DW'(p >>> sh);
   endfunction : mulq

   assign end_run = (state_reg == ST_RUN) && servo_tick && (elapsed_reg == dur_lat);

   ////////////////////////////////////////////////////////////////////////////
   // parameter checks, first failure wins
   always_comb begin
      check_err = ERR_NONE;
      if (!(loop_type == LOOP_ACC_FF || loop_type == LOOP_VEL_FF ||
            loop_type == LOOP_VOLT_DUAL_FF))
         check_err = ERR_LOOP;
      else if (64'(freq_lat) < FREQ_MIN_MHZ ||
               64'(freq_lat) * SERVO_PERIOD_US * 2 > FREQ_PERIOD_MAX)
         check_err = ERR_FREQ;
      else if (amp_lat <= 0)
         check_err = ERR_AMP;
      else if (dur_lat == '0)
         check_err = ERR_DUR;
      else if (setpoint_pos > upper_travel_bound ||
               DW'(setpoint_pos - (amp_lat <<< 1)) < lower_travel_bound)
         check_err = ERR_POS;
      else if (peak_v_reg < 0 || peak_v_reg > velocity_cap)
         check_err = ERR_VEL;
      else if (peak_a_reg < 0 || peak_a_reg > accel_cap)
         check_err = ERR_ACC;
   end

   ////////////////////////////////////////////////////////////////////////////
   // command sequencer
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         start_ack_reg <= 1'b0;
         start_err_reg <= 1'b0;
         err_code_reg <= ERR_NONE;
         freq_lat <= '0;
         amp_lat <= '0;
         dur_lat <= '0;
      end else begin
         start_ack_reg <= 1'b0;
         start_err_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (pre_corrector_excite_start) begin
                  if (pos_state_reg != POS_READY) begin
                     start_err_reg <= 1'b1;
                     err_code_reg <= ERR_NOT_READY;
                  end else begin
                     freq_lat <= freq_mhz;
                     amp_lat <= amplitude;
                     dur_lat <= duration_ticks;
                     state_reg <= ST_CALC_V;
                  end
               end
            end
            ST_CALC_V: state_reg <= ST_CALC_A;
            ST_CALC_A: state_reg <= ST_CALC_J;
            ST_CALC_J: state_reg <= ST_CHECK;
            ST_CHECK: begin
               err_code_reg <= check_err;
               if (check_err == ERR_NONE) begin
                  start_ack_reg <= 1'b1;
                  state_reg <= ST_RUN;
               end else begin
                  start_err_reg <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_RUN: if (end_run) state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // peak terms, one product per cycle
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         omega_reg <= '0;
         step_reg <= '0;
         peak_v_reg <= '0;
         peak_a_reg <= '0;
         peak_j_reg <= '0;
      end else begin
         case (state_reg)
            ST_CALC_V: begin
               omega_reg <= 32'((64'(freq_lat) * 64'(OMEGA_K)) >> 16);
               step_reg <= 32'((64'(freq_lat) * STEP_K) >> 16);
            end
            ST_CALC_A: peak_v_reg <= mulq(amp_lat, omega_reg, OMEGA_SH);
            ST_CALC_J: peak_a_reg <= mulq(peak_v_reg, omega_reg, OMEGA_SH);
            ST_CHECK: peak_j_reg <= mulq(peak_a_reg, omega_reg, OMEGA_SH);
            default: begin
            end
         endcase
      end
   end

   // readback of last accepted parameters
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         param_freq_reg <= '0;
         param_amp_reg <= '0;
         param_dur_reg <= '0;
      end else if (state_reg == ST_CHECK && check_err == ERR_NONE) begin
         param_freq_reg <= freq_lat;
         param_amp_reg <= amp_lat;
         param_dur_reg <= dur_lat;
      end
   end

   // positioner state and capture enable
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pos_state_reg <= POS_NOT_READY;
         capture_enable_reg <= 1'b0;
      end else begin
         if (state_reg == ST_CHECK && check_err == ERR_NONE) begin
            pos_state_reg <= POS_EXCITE;
            capture_enable_reg <= 1'b1;
         end else if (end_run || state_reg != ST_RUN) begin
            pos_state_reg <= group_ready ? POS_READY : POS_NOT_READY;
            capture_enable_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // phase and elapsed time per servo tick
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         phase_reg <= '0;
         elapsed_reg <= '0;
         look_reg <= 1'b0;
      end else begin
         look_reg <= 1'b0;
         if (state_reg != ST_RUN || end_run) begin
            phase_reg <= '0;
            elapsed_reg <= '0;
         end else if (servo_tick) begin
            look_reg <= 1'b1;
            phase_reg <= PHW'(phase_reg + step_reg);
            elapsed_reg <= TW'(elapsed_reg + 1'b1);
         end
      end
   end

   sine_rom u_sine_rom (
      .clk_sys(clk_sys),
      .phase_idx(phase_reg[PHW-1 -: 7]),
      .sin_q15_reg(sin_q),
      .cos_q15_reg(cos_q)
   );

   // the four terms, written in one cycle
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sine_valid_reg <= 1'b0;
         sine_pos_out_reg <= '0;
         sine_vel_out_reg <= '0;
         sine_acc_out_reg <= '0;
         sine_jerk_out_reg <= '0;
      end else begin
         sine_valid_reg <= look_reg || end_run;
         if (end_run) begin
            sine_pos_out_reg <= '0;
            sine_vel_out_reg <= '0;
            sine_acc_out_reg <= '0;
            sine_jerk_out_reg <= '0;
         end else if (look_reg && state_reg == ST_RUN) begin
            // table holds the phase sampled on the tick edge
            sine_pos_out_reg <= mulq(amp_lat, 32'(cos_q) - 32'sh7fff, SIN_SH);
            sine_vel_out_reg <= DW'(-mulq(peak_v_reg, 32'(sin_q), SIN_SH));
            sine_acc_out_reg <= DW'(-mulq(peak_a_reg, 32'(cos_q), SIN_SH));
            sine_jerk_out_reg <= mulq(peak_j_reg, 32'(sin_q), SIN_SH);
         end
      end
   end

   // corrector input and output adders
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         corr_pos_in_reg <= '0;
         corr_vel_in_reg <= '0;
         corr_acc_in_reg <= '0;
         corr_jerk_in_reg <= '0;
         drive_out_reg <= '0;
      end else begin
         corr_pos_in_reg <= DW'(traj_pos + sine_pos_out_reg);
         corr_vel_in_reg <= DW'(traj_vel + sine_vel_out_reg);
         corr_acc_in_reg <= DW'(traj_acc + sine_acc_out_reg);
         corr_jerk_in_reg <= DW'(traj_jerk + sine_jerk_out_reg);
         drive_out_reg <= post_corrector_excite_start ?
                          DW'(pid_out + post_excite_sig) : pid_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence run_tick;
      state_reg == ST_RUN && servo_tick && !end_run;
   endsequence
   sequence terms_written;
      ##2 sine_valid_reg;
   endsequence

   a_tick_recompute: assert property (run_tick |-> terms_written)
      else $error("tick did not refresh excitation terms");
   a_terms_together: assert property (($changed(sine_vel_out_reg) ||
      $changed(sine_jerk_out_reg) || $changed(sine_acc_out_reg)) |-> sine_valid_reg)
      else $error("excitation term changed without valid strobe");
   a_pos_start_zero: assert property ((run_tick and (phase_reg == '0)) |-> ##2
      sine_pos_out_reg == '0)
      else $error("position term not zero at phase zero");
   a_loop_reject: assert property (state_reg == ST_CHECK && check_err == ERR_LOOP
      |=> start_err_reg && !start_ack_reg && err_code_reg == ERR_LOOP)
      else $error("bad loop type not rejected");
   a_ready_gate: assert property (state_reg == ST_IDLE && pre_corrector_excite_start &&
      pos_state_reg != POS_READY |=> start_err_reg && state_reg == ST_IDLE)
      else $error("start taken while not ready");
   a_state_hold: assert property (state_reg == ST_RUN && !$past(end_run) &&
      $past(state_reg) == ST_RUN |-> pos_state_reg == POS_EXCITE)
      else $error("positioner left excitation state while running");
   a_freq_range: assert property (state_reg == ST_CHECK && check_err == ERR_NONE
      |-> freq_lat >= FW'(FREQ_MIN_MHZ) && step_reg <= 32'h80000000)
      else $error("frequency outside range accepted");
   a_amp_dur: assert property (start_ack_reg |-> $past(amp_lat) > 0 &&
      $past(dur_lat) != '0)
      else $error("zero amplitude or duration accepted");
   a_pos_bounds: assert property (start_ack_reg |-> $past(setpoint_pos) <=
      $past(upper_travel_bound))
      else $error("setpoint above upper bound accepted");
   a_peak_caps: assert property (start_ack_reg |-> peak_v_reg >= 0 &&
      peak_v_reg <= $past(velocity_cap) && peak_a_reg <= $past(accel_cap))
      else $error("peak over cap accepted");
   a_param_read: assert property (start_ack_reg |-> param_freq_reg == freq_lat &&
      param_amp_reg == amp_lat && param_dur_reg == dur_lat)
      else $error("readback does not match accepted parameters");
   a_capture_en: assert property (start_ack_reg |-> capture_enable_reg ##1
      (capture_enable_reg == (state_reg == ST_RUN || $past(end_run) == 1'b0)))
      else $error("capture not enabled with run");
   a_end_zero: assert property (end_run |=> sine_pos_out_reg == '0 &&
      sine_jerk_out_reg == '0 && elapsed_reg == '0 && state_reg == ST_IDLE)
      else $error("run end did not clear terms");
endmodule : pre_corrector_excite

// ==== src/excite_pkg.sv ====
/*
 shared constants for the pre-corrector sine excitation block.
 assumes one system clock and a servo-cycle tick produced elsewhere.
*/
package excite_pkg;
   // data widths
   localparam int DW = 48;
   localparam int FW = 32;
   localparam int TW = 32;
   localparam int PHW = 32;
   localparam int SINW = 16;
   localparam int SIN_SH = 15;
   localparam int OMEGA_SH = 8;
   localparam int POS_FRAC = 16;

   // servo timing
   localparam longint SERVO_PERIOD_US = 100;
   localparam longint MHZ_PER_HZ = 1000;
   localparam longint US_PER_S = 1000000;
   localparam longint FREQ_MIN_MHZ = 100;
   // f*t <= 0.5, written as f_mhz * t_us * 2 <= 1e9
   localparam longint FREQ_PERIOD_MAX = MHZ_PER_HZ * US_PER_S;
   localparam longint STEP_K = (SERVO_PERIOD_US * (64'h1 << 48)) / FREQ_PERIOD_MAX;
   // 2*pi*2^24/1000, omega in rad/s with 8 fraction bits after >>16
   localparam logic [31:0] OMEGA_K = 32'h00019bc6;

   // loop types
   localparam logic [2:0] LOOP_ACC_FF = 3'h1;
   localparam logic [2:0] LOOP_VEL_FF = 3'h2;
   localparam logic [2:0] LOOP_VOLT_DUAL_FF = 3'h3;

   // positioner state codes
   localparam logic [1:0] POS_NOT_READY = 2'h0;
   localparam logic [1:0] POS_READY = 2'h1;
   localparam logic [1:0] POS_EXCITE = 2'h2;

   // start error codes
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_NOT_READY = 4'h1;
   localparam logic [3:0] ERR_LOOP = 4'h2;
   localparam logic [3:0] ERR_FREQ = 4'h3;
   localparam logic [3:0] ERR_AMP = 4'h4;
   localparam logic [3:0] ERR_DUR = 4'h5;
   localparam logic [3:0] ERR_POS = 4'h6;
   localparam logic [3:0] ERR_VEL = 4'h7;
   localparam logic [3:0] ERR_ACC = 4'h8;

   typedef enum {ST_IDLE, ST_CALC_V, ST_CALC_A, ST_CALC_J, ST_CHECK, ST_RUN} excite_state_t;
endpackage : excite_pkg

// ==== src/sine_rom.sv ====
/*
 sine and cosine lookup with registered outputs, 128 steps per turn.
 assumes the phase index is held stable for the cycle it is sampled.
*/
module sine_rom
   import excite_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // lookup
   input wire logic [6:0] phase_idx,
   output logic signed [excite_pkg::SINW-1:0] sin_q15_reg,
   output logic signed [excite_pkg::SINW-1:0] cos_q15_reg
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] quarter(input logic [5:0] k);
      logic [15:0] v;
      v = 16'h0000;
      case (k)
         6'h00: v = 16'h0000; 6'h01: v = 16'h0648; 6'h02: v = 16'h0c8c; 6'h03: v = 16'h12c8;
         6'h04: v = 16'h18f9; 6'h05: v = 16'h1f1a; 6'h06: v = 16'h2528; 6'h07: v = 16'h2b1f;
         6'h08: v = 16'h30fb; 6'h09: v = 16'h36ba; 6'h0a: v = 16'h3c56; 6'h0b: v = 16'h41ce;
         6'h0c: v = 16'h471c; 6'h0d: v = 16'h4c3f; 6'h0e: v = 16'h5133; 6'h0f: v = 16'h55f5;
         6'h10: v = 16'h5a82; 6'h11: v = 16'h5ed7; 6'h12: v = 16'h62f1; 6'h13: v = 16'h66cf;
         6'h14: v = 16'h6a6d; 6'h15: v = 16'h6dc9; 6'h16: v = 16'h70e2; 6'h17: v = 16'h73b5;
         6'h18: v = 16'h7641; 6'h19: v = 16'h7884; 6'h1a: v = 16'h7a7c; 6'h1b: v = 16'h7c29;
         6'h1c: v = 16'h7d89; 6'h1d: v = 16'h7e9c; 6'h1e: v = 16'h7f61; 6'h1f: v = 16'h7fd8;
         6'h20: v = 16'h7fff;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : quarter

   // full-turn sine from quadrant symmetry
   function automatic logic signed [15:0] sine7(input logic [6:0] p);
      logic [5:0] k;
      logic [15:0] m;
      k = p[5] ? 6'(6'h20 - {1'b0, p[4:0]}) : {1'b0, p[4:0]};
      m = quarter(k);
      return p[6] ? -$signed(m) : $signed(m);
   endfunction : sine7

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      sin_q15_reg <= sine7(phase_idx);
      cos_q15_reg <= sine7(7'(phase_idx + 7'h20));
   end
endmodule : sine_rom

// ==== test/servo_corrector_model.sv ====
/*
 behavioural servo corrector on the far side of the excitation block.
 assumes one clock and a synchronous active-low reset shared with the block.
*/
module servo_corrector_model
   import excite_pkg::*;
#(
   parameter int TICK_CYCLES = 20
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // servo cycle
   output logic servo_tick = 1'b0,
   // trajectory points
   output logic signed [excite_pkg::DW-1:0] traj_pos = '0,
   output logic signed [excite_pkg::DW-1:0] traj_vel = '0,
   output logic signed [excite_pkg::DW-1:0] traj_acc = '0,
   output logic signed [excite_pkg::DW-1:0] traj_jerk = '0,
   // loop output
   output logic signed [excite_pkg::DW-1:0] pid_out = '0,
   output logic signed [excite_pkg::DW-1:0] post_excite_sig = '0
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // tick every TICK_CYCLES, at least 3 apart
   always @(posedge clk_sys) begin
      if (!resetn) begin
         cnt <= 0;
         servo_tick <= 1'b0;
      end else begin
         cnt <= (cnt == TICK_CYCLES - 1) ? 0 : cnt + 1;
         servo_tick <= (cnt == TICK_CYCLES - 1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // new point each servo cycle, held in between
   always @(posedge clk_sys) begin
      if (servo_tick) begin
         traj_pos <= traj_pos + 48'sh10000;
         traj_vel <= ~traj_vel;
         traj_acc <= traj_acc + 48'sh3;
         traj_jerk <= traj_jerk - 48'sh5;
         pid_out <= pid_out + 48'sh7;
         post_excite_sig <= ~post_excite_sig;
      end
   end
endmodule : servo_corrector_model

// ==== test/tb_pre_corrector_excite.sv ====
/*
 self-checking bench for the pre-corrector sine excitation block.
 assumes the servo corrector model supplies ticks, trajectory and loop output.
*/
module tb_pre_corrector_excite;
   timeunit 1ns;
   timeprecision 100ps;
   import excite_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic group_ready = 1'b0;
   logic pre_corrector_excite_start = 1'b0;
   logic post_corrector_excite_start = 1'b0;
   logic [2:0] loop_type = 3'h1;
   logic [FW-1:0] freq_mhz = '0;
   logic [TW-1:0] duration_ticks = '0;
   logic signed [DW-1:0] amplitude = '0, setpoint_pos = '0, upper_travel_bound = '0;
   logic signed [DW-1:0] lower_travel_bound = '0, velocity_cap = '0, accel_cap = '0;
   logic servo_tick, start_ack_reg, start_err_reg, capture_enable_reg, sine_valid_reg;
   logic [3:0] err_code_reg;
   logic [1:0] pos_state_reg;
   logic [FW-1:0] param_freq_reg;
   logic [TW-1:0] param_dur_reg;
   logic signed [DW-1:0] param_amp_reg, sine_pos_out_reg, sine_vel_out_reg;
   logic signed [DW-1:0] sine_acc_out_reg, sine_jerk_out_reg, traj_pos, traj_vel;
   logic signed [DW-1:0] traj_acc, traj_jerk, corr_pos_in_reg, corr_vel_in_reg;
   logic signed [DW-1:0] corr_acc_in_reg, corr_jerk_in_reg, pid_out, post_excite_sig;
   logic signed [DW-1:0] drive_out_reg;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   longint pv, pa;

   pre_corrector_excite i_dut (.clk_sys, .resetn, .servo_tick, .group_ready, .loop_type,
      .pre_corrector_excite_start, .freq_mhz, .amplitude, .duration_ticks, .start_ack_reg,
      .start_err_reg, .err_code_reg, .setpoint_pos, .upper_travel_bound, .lower_travel_bound,
      .velocity_cap, .accel_cap, .pos_state_reg, .capture_enable_reg, .param_freq_reg,
      .param_amp_reg, .param_dur_reg, .sine_valid_reg, .sine_pos_out_reg, .sine_vel_out_reg,
      .sine_acc_out_reg, .sine_jerk_out_reg, .traj_pos, .traj_vel, .traj_acc, .traj_jerk,
      .corr_pos_in_reg, .corr_vel_in_reg, .corr_acc_in_reg, .corr_jerk_in_reg,
      .post_corrector_excite_start, .pid_out, .post_excite_sig, .drive_out_reg);
   servo_corrector_model #(.TICK_CYCLES(20)) i_corr (.clk_sys, .resetn, .servo_tick,
      .traj_pos, .traj_vel, .traj_acc, .traj_jerk, .pid_out, .post_excite_sig);

   ////////////////////////////////////////////////////////////////////////////////
   // clock, timeout, helpers
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (n_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s seen %0h exp %0h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc
   // caps placed exactly on the peaks, bounds exactly on the travel
   task automatic limits(input longint f, input longint a);
      longint w;
      w = (f * longint'(OMEGA_K)) >>> 16;
      pv = (a * w) >>> 8;
      pa = (pv * w) >>> 8;
      setpoint_pos = '0;
      upper_travel_bound = '0;
      lower_travel_bound = DW'(-2 * a);
      velocity_cap = DW'(pv);
      accel_cap = DW'(pa);
   endtask : limits
   task automatic issue(input logic [2:0] lt, input logic [FW-1:0] f,
                        input logic signed [DW-1:0] a, input logic [TW-1:0] d);
      loop_type = lt;
      freq_mhz = f;
      amplitude = a;
      duration_ticks = d;
      pre_corrector_excite_start = 1'b1;
      cyc(1);
      pre_corrector_excite_start = 1'b0;
      for (int i = 0; i < 12; i++) begin
         if (start_ack_reg === 1'b1 || start_err_reg === 1'b1) break;
         cyc(1);
      end
   endtask : issue
   task automatic reject(input logic [2:0] lt, input logic [FW-1:0] f,
                         input logic signed [DW-1:0] a, input logic [TW-1:0] d,
                         input logic [3:0] code);
      issue(lt, f, a, d);
      check(DW'(start_err_reg), 1, "reject pulse");
      check(DW'(start_ack_reg), 0, "ack on reject");
      check(DW'(err_code_reg), DW'(code), "reject code");
      cyc(1);
   endtask : reject

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      check(DW'(pos_state_reg), DW'(POS_NOT_READY), "state after reset");
      check(DW'(param_freq_reg), 0, "param after reset");
      check(sine_pos_out_reg, 0, "term after reset");
      reject(LOOP_ACC_FF, 32'h3e8, 48'sh10000, 32'h2, ERR_NOT_READY);
      group_ready = 1'b1;
      cyc(2);
      check(DW'(pos_state_reg), DW'(POS_READY), "ready state");
   endtask : t_reset
   task automatic t_rejects();
      logic [2:0] bad_lt[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
      limits(100, 65536);
      foreach (bad_lt[i]) reject(bad_lt[i], 32'h64, 48'sh10000, 32'h2, ERR_LOOP);
      reject(LOOP_ACC_FF, 32'h63, 48'sh10000, 32'h2, ERR_FREQ);
      reject(LOOP_ACC_FF, 32'h4c4b41, 48'sh10000, 32'h2, ERR_FREQ);
      reject(LOOP_ACC_FF, 32'h64, 48'sh0, 32'h2, ERR_AMP);
      reject(LOOP_ACC_FF, 32'h64, 48'sh10000, 32'h0, ERR_DUR);
      setpoint_pos = 48'sh1;
      reject(LOOP_ACC_FF, 32'h64, 48'sh10000, 32'h2, ERR_POS);
      limits(100, 65536);
      lower_travel_bound = lower_travel_bound + 48'sh1;
      reject(LOOP_ACC_FF, 32'h64, 48'sh10000, 32'h2, ERR_POS);
      limits(100, 65536);
      velocity_cap = velocity_cap - 48'sh1;
      reject(LOOP_ACC_FF, 32'h64, 48'sh10000, 32'h2, ERR_VEL);
      limits(100, 65536);
      accel_cap = accel_cap - 48'sh1;
      reject(LOOP_ACC_FF, 32'h64, 48'sh10000, 32'h2, ERR_ACC);
   endtask : t_rejects
   task automatic t_run(input logic [2:0] lt, input logic [FW-1:0] f);
      int n, k, extra;
      longint d;
      logic [DW-1:0] last;
      n = 0;
      k = -1;
      extra = 0;
      last = '1;
      limits(longint'(f), 65536);
      issue(lt, f, 48'sh10000, 32'h2);
      check(DW'(start_ack_reg), 1, "ack");
      check(DW'(err_code_reg), DW'(ERR_NONE), "ok code");
      check(DW'(pos_state_reg), DW'(POS_EXCITE), "excite state");
      check(DW'(capture_enable_reg), 1, "capture on");
      check(DW'(param_freq_reg), DW'(f), "freq readback");
      check(param_amp_reg, 48'sh10000, "amp readback");
      check(DW'(param_dur_reg), 2, "dur readback");
      cyc(1);
      for (int i = 0; i < 200; i++) begin
         if (start_ack_reg === 1'b1 || start_err_reg === 1'b1) extra++;
         pre_corrector_excite_start = (i == 1);
         if (sine_valid_reg === 1'b1) begin
            n++;
            last = sine_pos_out_reg | sine_vel_out_reg | sine_acc_out_reg | sine_jerk_out_reg;
            if (n == 1) begin
               k = i + 3;
               d = longint'(sine_acc_out_reg) + pa;
               check(sine_pos_out_reg, 0, "phase zero pos");
               check(sine_vel_out_reg | sine_jerk_out_reg, 0, "phase zero sin");
               check(DW'(d < (pa >>> 10) + 2 && d > -(pa >>> 10) - 2), 1, "peak acc");
            end
         end
         if (i == k) begin
            check(corr_pos_in_reg, traj_pos + sine_pos_out_reg, "pos input");
            check(corr_vel_in_reg, traj_vel + sine_vel_out_reg, "vel input");
            check(corr_acc_in_reg, traj_acc + sine_acc_out_reg, "acc input");
            check(corr_jerk_in_reg, traj_jerk + sine_jerk_out_reg, "jerk input");
         end
         if (pos_state_reg === POS_READY) break;
         cyc(1);
      end
      check(DW'(n), 3, "updates per run");
      check(last, 0, "terms at end");
      check(DW'(extra), 0, "busy start answered");
      check(DW'(pos_state_reg), DW'(POS_READY), "back to ready");
      check(DW'(capture_enable_reg), 0, "capture off");
   endtask : t_run
   task automatic t_post();
      for (int i = 0; i < 40; i++) begin
         if (servo_tick === 1'b1 && post_excite_sig == '0) break;
         cyc(1);
      end
      cyc(4);
      post_corrector_excite_start = 1'b1;
      cyc(2);
      check(drive_out_reg, pid_out + post_excite_sig, "post path on");
      post_corrector_excite_start = 1'b0;
      cyc(2);
      check(drive_out_reg, pid_out, "post path off");
   endtask : t_post

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      cyc(2);
      t_reset();
      t_rejects();
      t_run(LOOP_ACC_FF, 32'h64);
      t_run(LOOP_VEL_FF, 32'h4c4b40);
      t_run(LOOP_VOLT_DUAL_FF, 32'h3e8);
      t_post();
      finish_test();
   end
endmodule : tb_pre_corrector_excite
